// File: ebh_pkg.sv
// package of constants and carrier types for the external bus handshake control
package ebh_pkg;

  // ********************************************************************
  // latch strobe pin selection codes
  // ********************************************************************
  localparam logic [1:0] EBH_LATCH_PIN_NONE = 2'h0;
  localparam logic [1:0] EBH_LATCH_PIN_A = 2'h1;
  localparam logic [1:0] EBH_LATCH_PIN_B = 2'h2;
  localparam logic [1:0] EBH_LATCH_PIN_C = 2'h3;
  localparam int EBH_LATCH_PINS = 4;

  // ********************************************************************
  // clock output selection and widths
  // ********************************************************************
  localparam logic [1:0] EBH_CLKFN_BUS_CLOCK = 2'h0;
  localparam logic EBH_CLKSEL_BUS_CLOCK = 1'b0;
  localparam int EBH_ADDR_W = 24;
  localparam int EBH_DATA_W = 16;
  localparam int EBH_CS_W = 4;
  localparam int EBH_WAIT_W = 4;
  localparam logic [EBH_ADDR_W-1:0] EBH_ADDR_RESET = 24'h000000;
  localparam logic [EBH_DATA_W-1:0] EBH_DATA_RESET = 16'h0000;
  localparam logic [EBH_CS_W-1:0] EBH_CS_IDLE = 4'hF;
  localparam logic [EBH_WAIT_W-1:0] EBH_WAIT_ZERO = 4'h0;

  // ********************************************************************
  // owners of the bus and an access request
  // ********************************************************************
  typedef enum logic [1:0] {
    EBH_OWN_CPU,
    EBH_OWN_DMA,
    EBH_OWN_EXT
  } ebh_owner_t;

  typedef struct packed {
    logic valid;
    logic external;
    logic write;
    logic byte_high;
    logic recovery;
    logic [EBH_WAIT_W-1:0] sw_waits;
    logic [EBH_CS_W-1:0] cs_n;
    logic [EBH_ADDR_W-1:0] addr;
    logic [EBH_DATA_W-1:0] wdata;
  } ebh_req_t;

  typedef struct packed {
    logic rd_n;
    logic wr_low_n;
    logic wr_high_n;
    logic byte_high_enable_n;
    logic [EBH_CS_W-1:0] cs_n;
    logic [EBH_ADDR_W-1:0] addr;
    logic [EBH_DATA_W-1:0] data;
    logic data_oe;
    logic ctl_oe;
  } ebh_pins_t;

endpackage // ebh_pkg

// File: ebh_sync.sv
// two flip-flop synchroniser for pin inputs
module ebh_sync
  import ebh_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // pin level
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  // first stage is read only by the second
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // ebh_sync

// File: ebh_ctrl.sv
// external bus handshake control: latch strobe, ready waits, hold, clock out
module ebh_ctrl
  import ebh_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // mode and pin configuration
  input wire logic single_chip_in,
  input wire logic multiplexed_in,
  input wire logic latch_pin_select_hi_in,
  input wire logic latch_pin_select_lo_in,
  input wire logic clock_output_select_in,
  input wire logic clock_out_function_hi_in,
  input wire logic clock_out_function_lo_in,
  input wire logic [EBH_DATA_W-1:0] port_value_in,
  // access requests from the cpu and the dma controller
  input wire ebh_req_t cpu_req_in,
  input wire ebh_req_t dma_req_in,
  output logic cpu_done_out,
  output logic dma_done_out,
  output logic [EBH_DATA_W-1:0] rdata_out,
  // external pins
  input wire logic ready_n_in,
  input wire logic hold_req_n_in,
  input wire logic [EBH_DATA_W-1:0] data_pin_in,
  output ebh_pins_t bus_out,
  output logic [EBH_LATCH_PINS-1:0] latch_strobe_out,
  output logic bus_hold_grant_n_out,
  output logic shared_clock_port_pin_out,
  output logic shared_clock_port_pin_oe_out,
  output logic [EBH_DATA_W-1:0] port_out,
  output logic watchdog_run_out
);

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic ready_n_s;
  logic hold_req_n_s;

  ebh_sync #(.RESET_VAL(1'b1)) u_ready_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .async_in(ready_n_in),
    .sync_out(ready_n_s)
  );

  ebh_sync #(.RESET_VAL(1'b1)) u_hold_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .async_in(hold_req_n_in),
    .sync_out(hold_req_n_s)
  );

  // ********************************************************************
  // access sequencer
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SWWAIT,
    ST_LAST,
    ST_RDYWAIT,
    ST_RECOVER,
    ST_HOLD,
    ST_RELEASE
  } ebh_state_t;

  ebh_state_t state;
  ebh_req_t cur;
  ebh_owner_t owner;
  ebh_owner_t next_owner;
  logic [EBH_WAIT_W-1:0] wait_cnt;
  logic [EBH_ADDR_W-1:0] last_addr;
  logic last_bhe;
  logic in_hold;
  logic ready_hold;

  // fixed priority of the bus owners
  always_comb begin
    if (!hold_req_n_s) begin
      next_owner = EBH_OWN_EXT;
    end else if (dma_req_in.valid) begin
      next_owner = EBH_OWN_DMA;
    end else begin
      next_owner = EBH_OWN_CPU;
    end
  end

  assign in_hold = (state == ST_HOLD);
  assign ready_hold = (state == ST_RDYWAIT);

  // state machine: access phases, waits, hold entry and release
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      owner <= EBH_OWN_CPU;
      wait_cnt <= EBH_WAIT_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          owner <= next_owner;
          if (next_owner == EBH_OWN_EXT) begin
            state <= ST_HOLD;
          end else if (next_owner == EBH_OWN_DMA || cpu_req_in.valid) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          wait_cnt <= cur.sw_waits;
          state <= (cur.sw_waits != EBH_WAIT_ZERO) ? ST_SWWAIT : ST_LAST;
        end
        ST_SWWAIT: begin
          // ready is not looked at before software waits end
          wait_cnt <= wait_cnt - 4'h1;
          if (wait_cnt == 4'h1) begin
            state <= ST_LAST;
          end
        end
        ST_LAST: begin
          if (cur.external && !ready_n_s) begin
            state <= ST_RDYWAIT;
          end else if (cur.recovery && cur.external && !multiplexed_in) begin
            state <= ST_RECOVER;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_RDYWAIT: begin
          if (ready_n_s) begin
            state <= (cur.recovery && !multiplexed_in) ? ST_RECOVER : ST_IDLE;
          end
        end
        ST_RECOVER: begin
          state <= ST_IDLE;
        end
        ST_HOLD: begin
          if (hold_req_n_s) begin
            state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // one cycle with outputs restored before any new owner starts
          state <= ST_IDLE;
          owner <= EBH_OWN_CPU;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // capture the granted request at the start of an access
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
    end else if (state == ST_IDLE && next_owner != EBH_OWN_EXT) begin
      cur <= (next_owner == EBH_OWN_DMA) ? dma_req_in : cpu_req_in;
    end
  end

  // completion pulses and read data
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_done_out <= 1'b0;
      dma_done_out <= 1'b0;
      rdata_out <= EBH_DATA_RESET;
    end else begin
      cpu_done_out <= 1'b0;
      dma_done_out <= 1'b0;
      if ((state == ST_LAST && (ready_n_s || !cur.external)) ||
          (state == ST_RDYWAIT && ready_n_s)) begin
        cpu_done_out <= (owner == EBH_OWN_CPU);
        dma_done_out <= (owner == EBH_OWN_DMA);
        if (!cur.write && cur.external) begin
          rdata_out <= data_pin_in;
        end
      end
    end
  end

  // ********************************************************************
  // bus pin drivers
  // ********************************************************************
  logic active;
  assign active = (state == ST_ADDR || state == ST_SWWAIT || state == ST_LAST);

  // remember last external address and byte-high level
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_addr <= EBH_ADDR_RESET;
      last_bhe <= 1'b1;
    end else if (state == ST_ADDR && cur.external) begin
      last_addr <= cur.addr;
      last_bhe <= !cur.byte_high;
    end
  end

  // registered pin image; frozen while ready holds the cycle
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_out <= '{rd_n: 1'b1, wr_low_n: 1'b1, wr_high_n: 1'b1,
                   byte_high_enable_n: 1'b1, cs_n: EBH_CS_IDLE, addr: EBH_ADDR_RESET,
                   data: EBH_DATA_RESET, data_oe: 1'b0, ctl_oe: 1'b1};
    end else if (ready_hold) begin
      bus_out <= bus_out;
    end else if (!hold_req_n_s && !active && state != ST_RECOVER) begin
      bus_out.ctl_oe <= 1'b0;
      bus_out.data_oe <= 1'b0;
    end else begin
      bus_out.ctl_oe <= 1'b1;
      bus_out.addr <= (active && cur.external) ? cur.addr : last_addr;
      bus_out.byte_high_enable_n <= (active && cur.external) ? !cur.byte_high : last_bhe;
      bus_out.rd_n <= !(active && cur.external && !cur.write);
      bus_out.wr_low_n <= !(active && cur.external && cur.write);
      bus_out.wr_high_n <= !(active && cur.external && cur.write && cur.byte_high);
      bus_out.cs_n <= (active && cur.external) ? cur.cs_n : EBH_CS_IDLE;
      bus_out.data <= cur.wdata;
      // recovery keeps write data driven one more cycle
      bus_out.data_oe <= cur.external && cur.write &&
                         (active || state == ST_RECOVER);
    end
  end

  // ********************************************************************
  // latch strobe, grant, ports, watchdog
  // ********************************************************************
  logic [1:0] latch_sel;
  logic latch_level;
  assign latch_sel = {latch_pin_select_hi_in, latch_pin_select_lo_in};

  // strobe high in the address phase of every access, low in hold
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_level <= 1'b0;
    end else if (ready_hold) begin
      latch_level <= latch_level;
    end else if (in_hold) begin
      latch_level <= 1'b0;
    end else begin
      latch_level <= (state == ST_ADDR);
    end
  end

  // route the strobe to the selected pin
  genvar gi;
  generate
    for (gi = 0; gi < EBH_LATCH_PINS; gi++) begin : g_latch
      assign latch_strobe_out[gi] = latch_level && (latch_sel == 2'(gi));
    end
  endgenerate

  // grant low while in hold; frozen during ready waits
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_hold_grant_n_out <= 1'b1;
    end else if (!ready_hold) begin
      bus_hold_grant_n_out <= !(state == ST_IDLE && next_owner == EBH_OWN_EXT ||
                                in_hold && !hold_req_n_s);
    end
  end

  // programmable ports frozen in ready waits and hold
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_out <= EBH_DATA_RESET;
    end else if (!ready_hold && !in_hold) begin
      port_out <= port_value_in;
    end
  end

  assign watchdog_run_out = !in_hold;

  // bus clock on the shared pin
  logic clk_out_en;
  assign clk_out_en = !single_chip_in && (clock_output_select_in == EBH_CLKSEL_BUS_CLOCK) &&
    ({clock_out_function_hi_in, clock_out_function_lo_in} == EBH_CLKFN_BUS_CLOCK);
  assign shared_clock_port_pin_out = clk_out_en && core_clk_in;
  assign shared_clock_port_pin_oe_out = clk_out_en;

  // ********************************************************************
  // checks
  // ********************************************************************
  chk_wait_freeze: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ready_hold && $past(ready_hold)) |-> $stable(bus_out.addr) && $stable(bus_out.rd_n))
    else $error("bus pins changed during ready wait");
  chk_ready_extends: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (state == ST_LAST && cur.external && !ready_n_s) |=> state == ST_RDYWAIT)
    else $error("ready low did not extend access");
  chk_ready_resume: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ready_hold && ready_n_s) |=> state != ST_RDYWAIT)
    else $error("ready high did not resume access");
  chk_swwait_noready: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    state == ST_SWWAIT |=> state != ST_RDYWAIT)
    else $error("ready taken during software waits");
  chk_hold_grant: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (in_hold && !hold_req_n_s) |=> !bus_hold_grant_n_out)
    else $error("grant not low in hold");
  chk_hold_float: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (in_hold && $past(in_hold)) |-> !bus_out.ctl_oe && !latch_level)
    else $error("bus driven in hold");
  chk_internal_idle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ($past(active) && !$past(cur.external) && !$past(ready_hold) && $past(hold_req_n_s))
    |-> bus_out.rd_n && bus_out.cs_n == EBH_CS_IDLE && !bus_out.data_oe)
    else $error("internal access disturbed external bus");
  chk_dma_priority: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (state == ST_IDLE && hold_req_n_s && dma_req_in.valid) |=> owner == EBH_OWN_DMA)
    else $error("dma lost to cpu");
  chk_release_gap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (in_hold && hold_req_n_s) |=> state == ST_RELEASE ##1 state == ST_IDLE)
    else $error("no release cycle after hold");
  chk_clock_single: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    single_chip_in |-> !shared_clock_port_pin_oe_out)
    else $error("clock driven in single-chip mode");

endmodule // ebh_ctrl

// File: ebh_far_model.sv
// far-side model: external memory that stretches ready, plus a hold requester
module ebh_far_model
  import ebh_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // bus pins and scenario controls
  input wire ebh_pins_t bus_in,
  input wire logic latch_in,
  input wire logic [3:0] wait_cycles_in,
  input wire logic hold_want_in,
  // answers to the device
  output logic ready_n_out,
  output logic hold_req_n_out,
  output logic [EBH_DATA_W-1:0] data_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [EBH_DATA_W-1:0] mem [16];
  logic [EBH_DATA_W-1:0] last;
  logic [3:0] cnt;
  logic [3:0] la;
  logic [3:0] idx;
  logic strobe;
  assign strobe = bus_in.ctl_oe && (!bus_in.rd_n || !bus_in.wr_low_n || !bus_in.wr_high_n);
  // slow device keeps ready low until the strobe has stood long enough
  assign ready_n_out = (cnt >= wait_cycles_in);
  // transparent address latch: follows the pins while the strobe is high, holds after its fall
  assign idx = latch_in ? bus_in.addr[3:0] : la;
  // read data only while read strobe is low, else a changing pattern
  assign data_pin_out = (strobe && !bus_in.rd_n) ? mem[idx] : ~last;
  // store writes, count strobe cycles, request the bus off a clock edge
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 4'h0;
      la <= 4'h0;
      last <= 16'h0000;
      hold_req_n_out <= 1'b1;
    end else begin
      last <= data_pin_out;
      hold_req_n_out <= !hold_want_in;
      if (latch_in) begin
        la <= bus_in.addr[3:0];
      end
      if (!strobe) begin
        cnt <= 4'h0;
      end else if (cnt != 4'hF) begin
        cnt <= cnt + 4'h1;
      end
      if (strobe && (!bus_in.wr_low_n || !bus_in.wr_high_n) && bus_in.data_oe) begin
        mem[idx] <= bus_in.data;
      end
    end
  end
endmodule // ebh_far_model

// File: tb_top.sv
// self-checking testbench for the external bus handshake control
module tb_top
  import ebh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic single_chip = 1'b0;
  logic mux = 1'b1;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic ck_sel = 1'b1;
  logic fn_hi = 1'b0;
  logic fn_lo = 1'b0;
  logic [EBH_DATA_W-1:0] port_value = 16'h1234;
  ebh_req_t cpu_req = '0;
  ebh_req_t dma_req = '0;
  logic [3:0] wait_cycles = 4'h0;
  logic hold_want = 1'b0;
  logic cpu_done, dma_done, ready_n, hold_req_n, grant, ck_pin, ck_oe, wdog;
  logic [EBH_DATA_W-1:0] rdata, data_pin, port;
  logic [EBH_LATCH_PINS-1:0] latch;
  ebh_pins_t bus;
  int fails = 0;
  int compares = 0;
  int stb, moved, early, cycles;
  logic [EBH_DATA_W-1:0] rd;
  logic [EBH_LATCH_PINS-1:0] seen;
  logic keep;

  always #10 core_clk_in = ~core_clk_in;

  ebh_ctrl ebh_ctrl_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .single_chip_in(single_chip), .multiplexed_in(mux), .latch_pin_select_hi_in(sel_hi),
    .latch_pin_select_lo_in(sel_lo), .clock_output_select_in(ck_sel),
    .clock_out_function_hi_in(fn_hi), .clock_out_function_lo_in(fn_lo),
    .port_value_in(port_value), .cpu_req_in(cpu_req), .dma_req_in(dma_req),
    .cpu_done_out(cpu_done), .dma_done_out(dma_done), .rdata_out(rdata),
    .ready_n_in(ready_n), .hold_req_n_in(hold_req_n), .data_pin_in(data_pin),
    .bus_out(bus), .latch_strobe_out(latch), .bus_hold_grant_n_out(grant),
    .shared_clock_port_pin_out(ck_pin), .shared_clock_port_pin_oe_out(ck_oe),
    .port_out(port), .watchdog_run_out(wdog));

  ebh_far_model ebh_far_model_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .bus_in(bus),
    .latch_in(|latch),
    .wait_cycles_in(wait_cycles), .hold_want_in(hold_want), .ready_n_out(ready_n),
    .hold_req_n_out(hold_req_n), .data_pin_out(data_pin));

  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic ebh_req_t mk(logic ext, logic wr, logic bh, logic [23:0] a, logic [15:0] d);
    ebh_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.external = ext;
    r.write = wr;
    r.byte_high = bh;
    r.cs_n = ext ? 4'hE : EBH_CS_IDLE;
    r.addr = a;
    r.wdata = d;
    return r;
  endfunction

  // present a request, watch the pins until done, then withdraw it
  task automatic access(input logic dma, input ebh_req_t r);
    int n;
    n = 0;
    seen = '0;
    stb = 0;
    moved = 0;
    early = 0;
    if (dma) dma_req = r;
    else cpu_req = r;
    do begin
      @(posedge core_clk_in);
      #1;
      seen = seen | latch;
      if (!bus.rd_n || !bus.wr_low_n || !bus.wr_high_n) stb++;
      if (stb > 0 && bus.addr !== r.addr && r.external) moved++;
      if (grant !== 1'b1) early++;
      keep = bus.byte_high_enable_n;
      n++;
    end while ((dma ? dma_done : cpu_done) !== 1'b1 && n < 60);
    cycles = n;
    chk("done_seen", 1, n < 60);
    rd = rdata;
    cpu_req.valid = 1'b0;
    dma_req.valid = 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_latch_pins();
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} = s[1:0];
      access(0, mk(1, 1, 1, 24'h000100 + s, 16'hA5C0 + s));
      chk("latch_pin", 4'h1 << s, seen);
    end
    for (int s = 0; s < 4; s++) begin
      access(1, mk(1, 0, 1, 24'h000100 + s, 16'h0000));
      chk("rdata", 16'hA5C0 + s, rd);
    end
  endtask

  task automatic t_ready();
    int base;
    ebh_req_t r;
    access(0, mk(1, 0, 1, 24'h000102, 16'h0000));
    base = stb;
    wait_cycles = 4'h6;
    access(0, mk(1, 0, 1, 24'h000102, 16'h0000));
    chk("rd_low_long", 1, stb >= 6 && stb > base);
    chk("addr_frozen", 0, moved);
    chk("rdata_waited", 16'hA5C2, rd);
    // ready low only while software waits run must not stretch the access
    wait_cycles = 4'h1;
    r = mk(1, 0, 1, 24'h000102, 16'h0000);
    r.sw_waits = 4'h3;
    access(0, r);
    chk("sw_cycles", 6, cycles);
    chk("rdata_sw", 16'hA5C2, rd);
    wait_cycles = 4'h0;
  endtask

  task automatic t_internal();
    access(0, mk(1, 1, 1, 24'h000107, 16'h5A5A));
    access(0, mk(0, 1, 0, 24'h00ABCD, 16'h3C3C));
    chk("int_strobes", 0, stb);
    chk("int_latch", 1, seen != 0);
    chk("int_addr", 24'h000107, bus.addr);
    chk("int_data_oe", 0, bus.data_oe);
    chk("int_cs", EBH_CS_IDLE, bus.cs_n);
    chk("int_bhe", 0, keep);
  endtask

  task automatic t_hold();
    int n;
    ebh_req_t r;
    chk("wdog_run", 1, wdog);
    hold_want = 1'b1;
    wait_cycles = 4'h4;
    access(0, mk(1, 0, 1, 24'h000101, 16'h0000));
    wait_cycles = 4'h0;
    chk("grant_before_done", 0, early);
    chk("hold_rdata", 16'hA5C1, rd);
    n = 0;
    while (grant !== 1'b0 && n < 20) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    chk("grant_low", 0, grant);
    port_value = 16'h4321;
    r = mk(1, 0, 1, 24'h000103, 16'h0000);
    cpu_req = r;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in);
      #1;
      chk("hold_no_done", 0, cpu_done);
      chk("hold_grant", 0, grant);
      chk("hold_ctl_oe", 0, bus.ctl_oe);
      chk("hold_data_oe", 0, bus.data_oe);
      chk("hold_latch", 0, latch);
      chk("hold_port", 16'h1234, port);
      chk("hold_wdog", 0, wdog);
    end
    hold_want = 1'b0;
    access(0, r);
    chk("release_grant", 1, grant);
    chk("release_ctl_oe", 1, bus.ctl_oe);
  endtask

  task automatic t_prio();
    int n;
    n = 0;
    cpu_req = mk(1, 0, 1, 24'h000100, 16'h0000);
    dma_req = mk(1, 0, 1, 24'h000101, 16'h0000);
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (dma_done !== 1'b1 && cpu_done !== 1'b1 && n < 60);
    chk("dma_first", 2'b10, {dma_done, cpu_done});
    dma_req.valid = 1'b0;
    access(0, cpu_req);
    chk("cpu_after", 16'hA5C0, rd);
  endtask

  task automatic t_recovery();
    ebh_req_t r;
    r = mk(1, 1, 1, 24'h000105, 16'hC3A5);
    r.recovery = 1'b1;
    mux = 1'b0;
    access(0, r);
    chk("rec_data_oe", 1, bus.data_oe);
    chk("rec_data", 16'hC3A5, bus.data);
    chk("rec_addr", 24'h000105, bus.addr);
    chk("rec_strobe", 1, bus.wr_low_n);
    mux = 1'b1;
    access(0, r);
    chk("mux_no_rec", 0, bus.data_oe);
  endtask

  task automatic t_clock_out();
    for (int i = 0; i < 16; i++) begin
      {single_chip, ck_sel, fn_hi, fn_lo} = i[3:0];
      @(posedge core_clk_in);
      #1;
      chk("clk_oe", i == 0, ck_oe);
      chk("clk_pin", i == 0, ck_pin);
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1;
    chk("rst_grant", 1, grant);
    chk("rst_latch", 0, latch);
    chk("rst_ctl", 2'b10, {bus.ctl_oe, bus.data_oe});
    repeat (4) @(posedge core_clk_in);
    #1;
    nrst_in = 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1;
    t_latch_pins();
    t_ready();
    t_internal();
    t_hold();
    t_prio();
    t_recovery();
    t_clock_out();
    summarize();
  end

  // watchdog against a hang
  initial begin
    #100us;
    fails++;
    summarize();
  end
endmodule // tb_top
